//--- tmr16_timer.sv
// 16-bit timer with two capture/compare registers, overflow flag and one-shot output.
`timescale 1ns/1ns
module tmr16_timer
(
    // Clock and reset
    input wire logic clock_i,
    input wire logic reset_i,
    // Configuration
    input wire tmr16_pkg::tmr_cfg_s cfg_i,
    // Software strobes
    input wire logic ovf_clear_i,
    input wire logic oneshot_sw_trig_i,
    input wire logic cc_a_wr_i,
    input wire logic cc_b_wr_i,
    input wire logic [15:0] wr_data_i,
    input wire logic rd_i,
    input wire tmr16_pkg::tmr_rdsel_e rd_sel_i,
    // External pins
    input wire logic trigger_capture_pin_a_i,
    input wire logic capture_pin_b_i,
    // Status and data
    output logic [15:0] up_counter_o,
    output logic [15:0] capture_compare_a_o,
    output logic [15:0] capture_compare_b_o,
    output logic [15:0] read_data_o,
    output logic overflow_flag_o,
    output logic capture_irq_a_o,
    output logic capture_irq_b_o,
    output logic oneshot_o
);

    // ----------------------------------------------------------------
    // Mode decode
    // ----------------------------------------------------------------
    tmr16_pkg::tmr_mode_e mode;
    logic running;
    logic os_ok;
    logic match_mode;

    assign mode = tmr16_pkg::tmr_mode_e'({cfg_i.op_mode_bit_hi, cfg_i.op_mode_bit_lo});
    assign running = (mode != tmr16_pkg::MODE_STOP);
    assign match_mode = (mode == tmr16_pkg::MODE_CLEAR_MATCH);
    assign os_ok = (mode == tmr16_pkg::MODE_FREE_RUN)
                || (mode == tmr16_pkg::MODE_CLEAR_EDGE);

    // ----------------------------------------------------------------
    // Pin synchronisers
    // ----------------------------------------------------------------
    logic [1:0] pa_q;
    logic [1:0] pb_q;
    logic pa_last_q;

    always_ff @(posedge clock_i)
    begin
        if (reset_i)
        begin
            pa_q <= tmr16_pkg::SAMP_NONE;
            pb_q <= tmr16_pkg::SAMP_NONE;
            pa_last_q <= 1'b0;
        end
        else
        begin
            pa_q <= {pa_q[0], trigger_capture_pin_a_i};
            pb_q <= {pb_q[0], capture_pin_b_i};
            pa_last_q <= pa_q[1];
        end
    end

    // ----------------------------------------------------------------
    // Count clock
    // ----------------------------------------------------------------
    logic [3:0] psc_q;
    logic [3:0] mask;
    logic rise;
    logic fall;
    logic cnt_tick;

    assign mask = tmr16_pkg::div_mask(cfg_i.presc_sel);
    assign rise = running && ((psc_q & mask) == mask);
    assign fall = running && ((psc_q & mask) == (mask >> 1));
    assign cnt_tick = running && (cfg_i.count_on_pin ? (pa_q[1] && !pa_last_q) : rise);

    always_ff @(posedge clock_i)
    begin
        if (reset_i || !running)
        begin
            psc_q <= tmr16_pkg::PSC_ZERO;
        end
        else
        begin
            psc_q <= psc_q + 4'h1;
        end
    end

    // ----------------------------------------------------------------
    // Noise filter and capture pipeline
    // ----------------------------------------------------------------
    logic [1:0] samp_q [2];
    logic [1:0] lvl_q;
    logic [1:0] edge_v;
    logic [1:0] cap_en;
    logic [1:0] pend_q;
    logic [1:0] irq_pend_q;
    logic [1:0] cap_load;
    logic [1:0] pin_lvl;

    assign pin_lvl = {pa_q[1], pb_q[1]};
    assign cap_en[tmr16_pkg::CH_A] = cfg_i.cap_a_en;
    assign cap_en[tmr16_pkg::CH_B] = cfg_i.cap_b_en && !cfg_i.count_on_pin;
    // Filter index 1 watches pin a, index 0 watches pin b.
    assign edge_v[1] = rise && (samp_q[1] == tmr16_pkg::SAMP_BOTH) && !lvl_q[1];
    assign edge_v[0] = rise && (samp_q[0] == tmr16_pkg::SAMP_BOTH) && !lvl_q[0];
    assign cap_load = pend_q & cap_en & {2{fall}};

    always_ff @(posedge clock_i)
    begin
        for (int i = 0; i < 2; i++)
        begin
            if (reset_i || !running)
            begin
                samp_q[i] <= tmr16_pkg::SAMP_NONE;
                lvl_q[i] <= 1'b0;
            end
            else if (rise)
            begin
                samp_q[i] <= {samp_q[i][0], pin_lvl[i]};
                if (samp_q[i] == tmr16_pkg::SAMP_BOTH)
                begin
                    lvl_q[i] <= 1'b1;
                end
                else if (samp_q[i] == tmr16_pkg::SAMP_NONE)
                begin
                    lvl_q[i] <= 1'b0;
                end
            end
        end
    end

    // Register a captures on pin b edges, register b on pin a edges.
    always_ff @(posedge clock_i)
    begin
        if (reset_i || !running)
        begin
            pend_q <= 2'h0;
        end
        else
        begin
            if (edge_v[0] && cap_en[tmr16_pkg::CH_A])
            begin
                pend_q[tmr16_pkg::CH_A] <= 1'b1;
            end
            else if (fall)
            begin
                pend_q[tmr16_pkg::CH_A] <= 1'b0;
            end
            if (edge_v[1] && cap_en[tmr16_pkg::CH_B])
            begin
                pend_q[tmr16_pkg::CH_B] <= 1'b1;
            end
            else if (fall)
            begin
                pend_q[tmr16_pkg::CH_B] <= 1'b0;
            end
        end
    end

    always_ff @(posedge clock_i)
    begin
        if (reset_i || !running)
        begin
            irq_pend_q <= 2'h0;
            capture_irq_a_o <= 1'b0;
            capture_irq_b_o <= 1'b0;
        end
        else
        begin
            irq_pend_q <= cap_load | (irq_pend_q & ~{2{rise}});
            capture_irq_a_o <= rise && irq_pend_q[tmr16_pkg::CH_A];
            capture_irq_b_o <= rise && irq_pend_q[tmr16_pkg::CH_B];
        end
    end

    // ----------------------------------------------------------------
    // Capture/compare registers and read port
    // ----------------------------------------------------------------
    always_ff @(posedge clock_i)
    begin
        if (reset_i)
        begin
            capture_compare_a_o <= tmr16_pkg::CNT_ZERO;
            capture_compare_b_o <= tmr16_pkg::CNT_ZERO;
        end
        else
        begin
            if (cap_load[tmr16_pkg::CH_A])
            begin
                capture_compare_a_o <= up_counter_o;
            end
            else if (cc_a_wr_i)
            begin
                capture_compare_a_o <= wr_data_i;
            end
            // Only a capture or a write changes register b; counter reads do not.
            if (cap_load[tmr16_pkg::CH_B])
            begin
                capture_compare_b_o <= up_counter_o;
            end
            else if (cc_b_wr_i)
            begin
                capture_compare_b_o <= wr_data_i;
            end
        end
    end

    // A read that meets a capture returns the captured value.
    always_ff @(posedge clock_i)
    begin
        if (reset_i)
        begin
            read_data_o <= tmr16_pkg::CNT_ZERO;
        end
        else if (rd_i)
        begin
            unique case (rd_sel_i)
                tmr16_pkg::RD_CC_A:
                    read_data_o <= cap_load[tmr16_pkg::CH_A] ? up_counter_o
                                 : capture_compare_a_o;
                tmr16_pkg::RD_CC_B:
                    read_data_o <= cap_load[tmr16_pkg::CH_B] ? up_counter_o
                                 : capture_compare_b_o;
                default:
                    read_data_o <= up_counter_o;
            endcase
        end
    end

    // ----------------------------------------------------------------
    // Counter and overflow
    // ----------------------------------------------------------------
    logic os_trig;
    logic edge_clear;
    logic match_clear;
    logic wrap;
    logic ovf_hold_q;

    assign os_trig = running && os_ok && cfg_i.oneshot_en
                  && (oneshot_sw_trig_i || edge_v[1]);
    assign edge_clear = (mode == tmr16_pkg::MODE_CLEAR_EDGE) && edge_v[1];
    assign match_clear = match_mode && (up_counter_o == capture_compare_a_o);
    assign wrap = cnt_tick && !os_trig && !edge_clear
               && (up_counter_o == tmr16_pkg::CNT_MAX);

    always_ff @(posedge clock_i)
    begin
        if (reset_i || !running)
        begin
            up_counter_o <= tmr16_pkg::CNT_ZERO;
        end
        else if (os_trig || edge_clear)
        begin
            up_counter_o <= tmr16_pkg::CNT_ZERO;
        end
        else if (cnt_tick)
        begin
            if (match_clear)
            begin
                up_counter_o <= tmr16_pkg::CNT_ZERO;
            end
            else
            begin
                up_counter_o <= up_counter_o + tmr16_pkg::CNT_ONE;
            end
        end
    end

    // The hold window lasts from the wrap until the counter reaches one.
    always_ff @(posedge clock_i)
    begin
        if (reset_i)
        begin
            ovf_hold_q <= 1'b0;
            overflow_flag_o <= 1'b0;
        end
        else
        begin
            if (wrap)
            begin
                ovf_hold_q <= 1'b1;
            end
            else if (cnt_tick || !running)
            begin
                ovf_hold_q <= 1'b0;
            end
            overflow_flag_o <= wrap || ovf_hold_q
                            || (overflow_flag_o && !ovf_clear_i);
        end
    end

    // ----------------------------------------------------------------
    // One-shot pulse
    // ----------------------------------------------------------------
    tmr16_pkg::tmr_os_e os_q;

    assign oneshot_o = (os_q == tmr16_pkg::OS_PULSE);

    always_ff @(posedge clock_i)
    begin
        if (reset_i || !os_ok || !running)
        begin
            os_q <= tmr16_pkg::OS_IDLE;
        end
        else if (os_trig)
        begin
            os_q <= tmr16_pkg::OS_DELAY;
        end
        else if (cnt_tick)
        begin
            unique case (os_q)
                tmr16_pkg::OS_DELAY:
                    if (up_counter_o == capture_compare_b_o)
                    begin
                        os_q <= tmr16_pkg::OS_PULSE;
                    end
                tmr16_pkg::OS_PULSE:
                    if (up_counter_o == capture_compare_a_o)
                    begin
                        os_q <= tmr16_pkg::OS_IDLE;
                    end
                default:
                    os_q <= os_q;
            endcase
        end
    end

    // ----------------------------------------------------------------
    // Assertions
    // ----------------------------------------------------------------
    default clocking cb @(posedge clock_i); endclocking
    default disable iff (reset_i);

    a_stop_holds: assert property (!running |=> up_counter_o == tmr16_pkg::CNT_ZERO)
        else $error("Counter moved while stopped.");
    a_count_step: assert property (cnt_tick && running && !os_trig && !edge_clear
        && !match_clear |=> up_counter_o == $past(up_counter_o) + tmr16_pkg::CNT_ONE)
        else $error("Counter did not step on a count tick.");
    a_os_pin_trig: assert property (running && os_ok && cfg_i.oneshot_en && edge_v[1]
        |=> up_counter_o == tmr16_pkg::CNT_ZERO && os_q == tmr16_pkg::OS_DELAY)
        else $error("Pin edge did not restart the one-shot.");
    a_ovf_wrap: assert property (running && cnt_tick && !os_trig && !edge_clear
        && up_counter_o == tmr16_pkg::CNT_MAX |=> overflow_flag_o)
        else $error("Wrap did not set overflow.");
    a_ovf_clear_void: assert property (ovf_hold_q && ovf_clear_i |=> overflow_flag_o)
        else $error("Overflow cleared inside the hold window.");
    a_cap_prio: assert property (cap_load[tmr16_pkg::CH_A]
        |=> capture_compare_a_o == $past(up_counter_o))
        else $error("Capture lost against software access.");
    a_cnt_read: assert property (rd_i && rd_sel_i == tmr16_pkg::RD_COUNTER
        && !cap_load[tmr16_pkg::CH_B] && !cc_b_wr_i |=> $stable(capture_compare_b_o))
        else $error("Counter read changed register b.");
    a_stop_ignore: assert property (!running |=> pend_q == 2'h0 && !capture_irq_a_o
        && !capture_irq_b_o)
        else $error("Pin acknowledged while stopped.");
    a_os_mode: assert property (match_mode |=> !oneshot_o)
        else $error("One-shot pulse in clear-on-match mode.");
    a_pin_clock: assert property (cfg_i.count_on_pin |-> !cap_load[tmr16_pkg::CH_B])
        else $error("Register b captured while pin a is the clock.");
    a_irq_follow: assert property (cap_load[tmr16_pkg::CH_A]
        |-> ##[1:9] (capture_irq_a_o || !running))
        else $error("Capture request did not follow the load.");
    a_irq_on_rise: assert property (capture_irq_b_o |-> $past(rise))
        else $error("Capture request not on a rising edge.");
    a_compare_ign: assert property (!cfg_i.cap_a_en |-> !cap_load[tmr16_pkg::CH_A])
        else $error("Compare register captured.");
    a_filter_two: assert property ($rose(pend_q[tmr16_pkg::CH_A])
        |-> $past(samp_q[0]) == tmr16_pkg::SAMP_BOTH)
        else $error("Capture without two valid samples.");

    c_cap_a: cover property (capture_irq_a_o);
    c_ovf: cover property (wrap);
    c_os: cover property (oneshot_o);
    c_cap_b: cover property (capture_irq_b_o);

endmodule : tmr16_timer

//--- tmr16_pkg.sv
// Constants, types and helpers for the 16-bit capture and one-shot timer.
// Functional notes
// - The counter is held stopped while the mode bits read 00 and counts once another mode is set.
// - With software one-shot armed, a valid edge on pin a still clears, restarts and pulses.
// - In clear-on-match, clear-on-edge or free-run mode with register a at FFFFH the wrap sets overflow.
// - Clearing overflow after a wrap but before the counter reaches 0001H has no effect.
// - A capture that meets a software read of the same register wins, and the read returns the captured value.
// - Reading the counter never loads the counter into capture/compare register b.
// - While the counter is stopped both input pins are ignored in every processor mode.
// - One-shot output works only in free-run or clear-on-edge mode, never in clear-on-match.
// - When pin a edges are the count clock, register b cannot capture from pin a.
// - A capture needs the valid level sampled twice on the count clock, rejecting short noise.
// - A capture loads on the count clock falling edge and its request rises on the next rising edge.
// - A register set for compare may ignore capture triggers.
package tmr16_pkg;

    // ----------------------------------------------------------------
    // Widths and values
    // ----------------------------------------------------------------
    localparam int CNT_W = 16;
    localparam int PSC_W = 4;
    localparam logic [CNT_W-1:0] CNT_ZERO = 16'h0000;
    localparam logic [CNT_W-1:0] CNT_ONE = 16'h0001;
    localparam logic [CNT_W-1:0] CNT_MAX = 16'hffff;
    localparam logic [PSC_W-1:0] PSC_ZERO = 4'h0;
    localparam logic [PSC_W:0] PSC_BASE = 5'h02;
    localparam logic [PSC_W:0] PSC_ONE = 5'h01;
    localparam logic [1:0] SAMP_BOTH = 2'h3;
    localparam logic [1:0] SAMP_NONE = 2'h0;
    localparam int CH_A = 0;
    localparam int CH_B = 1;

    // ----------------------------------------------------------------
    // Types
    // ----------------------------------------------------------------
    typedef enum logic [1:0] {
        MODE_STOP,
        MODE_FREE_RUN,
        MODE_CLEAR_EDGE,
        MODE_CLEAR_MATCH
    } tmr_mode_e;

    typedef enum logic [1:0] {
        RD_COUNTER,
        RD_CC_A,
        RD_CC_B
    } tmr_rdsel_e;

    typedef enum logic [1:0] {
        OS_IDLE,
        OS_DELAY,
        OS_PULSE
    } tmr_os_e;

    typedef struct packed {
        logic op_mode_bit_hi;
        logic op_mode_bit_lo;
        logic [1:0] presc_sel;
        logic count_on_pin;
        logic cap_a_en;
        logic cap_b_en;
        logic oneshot_en;
    } tmr_cfg_s;

    // Low-bit mask of the prescaler for a divide by 2, 4, 8 or 16.
    function automatic logic [PSC_W-1:0] div_mask(input logic [1:0] sel);
        logic [PSC_W:0] m;
        m = (PSC_BASE << sel) - PSC_ONE;
        return m[PSC_W-1:0];
    endfunction : div_mask

endpackage : tmr16_pkg

//--- tmr16_pin_model.sv
// Model of the outside sources that drive the trigger and capture pins.
`timescale 1ns/1ns
module tmr16_pin_model
(
    // Clock
    input wire logic clock_i,
    // Pins
    output logic trigger_capture_pin_a_o,
    output logic capture_pin_b_o
);
    initial
    begin
        trigger_capture_pin_a_o = 1'b0;
        capture_pin_b_o = 1'b0;
    end

    // Raw high pulse of the given length on pin a (0) or pin b (1); pins idle low.
    task automatic pulse(input int pin, input int cycles);
        @(posedge clock_i);
        #1;
        if (pin == 0)
            trigger_capture_pin_a_o = 1'b1;
        else
            capture_pin_b_o = 1'b1;
        repeat (cycles) @(posedge clock_i);
        #1;
        trigger_capture_pin_a_o = 1'b0;
        capture_pin_b_o = 1'b0;
    endtask : pulse

    // Trigger held for three count clock periods of the given divisor.
    task automatic hold_capture(input int pin, input int div);
        pulse(pin, 3 * div);
    endtask : hold_capture
endmodule : tmr16_pin_model

//--- tmr16_timer_tb.sv
// Self-checking testbench of the 16-bit capture and one-shot timer.
`timescale 1ns/1ns
module tmr16_timer_tb;
    logic clock_i, reset_i, ovf_clear_i, oneshot_sw_trig_i, cc_a_wr_i, cc_b_wr_i, rd_i;
    tmr16_pkg::tmr_cfg_s cfg_i;
    tmr16_pkg::tmr_rdsel_e rd_sel_i;
    logic [15:0] wr_data_i, up_counter_o, capture_compare_a_o, capture_compare_b_o, read_data_o;
    logic pin_a, pin_b, overflow_flag_o, capture_irq_a_o, capture_irq_b_o, oneshot_o, os_prev;
    int num_errors = 0;
    int compares = 0;
    int cyc = 0;
    int irq_a_n = 0;
    int irq_b_n = 0;
    int os_n = 0;

    tmr16_timer DUT (.clock_i(clock_i), .reset_i(reset_i), .cfg_i(cfg_i),
        .ovf_clear_i(ovf_clear_i), .oneshot_sw_trig_i(oneshot_sw_trig_i),
        .cc_a_wr_i(cc_a_wr_i), .cc_b_wr_i(cc_b_wr_i), .wr_data_i(wr_data_i), .rd_i(rd_i),
        .rd_sel_i(rd_sel_i), .trigger_capture_pin_a_i(pin_a), .capture_pin_b_i(pin_b),
        .up_counter_o(up_counter_o), .capture_compare_a_o(capture_compare_a_o),
        .capture_compare_b_o(capture_compare_b_o), .read_data_o(read_data_o),
        .overflow_flag_o(overflow_flag_o), .capture_irq_a_o(capture_irq_a_o),
        .capture_irq_b_o(capture_irq_b_o), .oneshot_o(oneshot_o));

    tmr16_pin_model pins (.clock_i(clock_i), .trigger_capture_pin_a_o(pin_a),
        .capture_pin_b_o(pin_b));

    initial
    begin
        clock_i = 1'b0;
        forever #25 clock_i = ~clock_i;
    end

    // Event counters sampled on each rising edge.
    always @(posedge clock_i)
    begin
        cyc <= cyc + 1;
        os_prev <= oneshot_o;
        if (capture_irq_a_o === 1'b1)
            irq_a_n <= irq_a_n + 1;
        if (capture_irq_b_o === 1'b1)
            irq_b_n <= irq_b_n + 1;
        if (oneshot_o === 1'b1 && os_prev === 1'b0)
            os_n <= os_n + 1;
    end

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    task automatic check(input logic [15:0] seen, input logic [15:0] exp, input string msg);
        compares++;
        if (seen !== exp)
        begin
            num_errors++;
            $display("mismatch at %0t: %s seen %h expected %h", $time, msg, seen, exp);
        end
    endtask : check

    task automatic step(input int n);
        repeat (n) @(posedge clock_i);
        #1;
    endtask : step

    // Stops the timer, then starts it with mode, prescaler and {pin,cap_a,cap_b,oneshot}.
    task automatic run(input logic [1:0] m, input logic [1:0] p, input logic [3:0] f);
        cfg_i = 8'h00;
        step(2);
        cfg_i = {m, p, f};
        step(1);
    endtask : run

    task automatic wr_cc(input logic sel_b, input logic [15:0] v);
        wr_data_i = v;
        cc_a_wr_i = ~sel_b;
        cc_b_wr_i = sel_b;
        step(1);
        cc_a_wr_i = 1'b0;
        cc_b_wr_i = 1'b0;
        step(1);
    endtask : wr_cc

    task automatic finish_test;
        $display("comparisons %0d mismatches %0d", compares, num_errors);
        if (num_errors == 0 && compares > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask : finish_test

    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task automatic t_reset;
        check(up_counter_o | capture_compare_a_o | capture_compare_b_o, 16'h0000, "reset data");
        check(16'({overflow_flag_o, capture_irq_a_o, capture_irq_b_o, oneshot_o}), 16'h0000,
            "reset flags");
    endtask : t_reset

    task automatic t_stopped;
        int na;
        int nb;
        na = irq_a_n;
        nb = irq_b_n;
        cfg_i = 8'h06;
        pins.hold_capture(1, 2);
        pins.hold_capture(0, 2);
        step(10);
        check(up_counter_o, 16'h0000, "stopped counter");
        check(16'(irq_a_n + irq_b_n), 16'(na + nb), "capture while stopped");
    endtask : t_stopped

    task automatic t_count;
        run(2'h1, 2'h0, 4'h0);
        check(up_counter_o, 16'h0000, "count start");
        step(1);
        check(up_counter_o, 16'h0001, "first step");
        step(2);
        check(up_counter_o, 16'h0002, "second step");
        step(20);
        check(up_counter_o, 16'h000c, "div2 rate");
    endtask : t_count

    task automatic t_capture;
        int na;
        int t1;
        int t2;
        run(2'h1, 2'h3, 4'h4);
        na = irq_a_n;
        pins.pulse(1, 6);
        step(40);
        check(16'(irq_a_n), 16'(na), "glitch captured");
        fork
            pins.hold_capture(1, 16);
            begin
                for (t1 = 0; t1 < 80 && capture_compare_a_o === 16'h0000; t1++) step(1);
                t1 = cyc;
                for (t2 = 0; t2 < 40 && capture_irq_a_o !== 1'b1; t2++) step(1);
                t2 = cyc;
            end
        join
        step(1);
        check(16'(t2 - t1), 16'h0008, "load to request gap");
        check(16'(irq_a_n), 16'(na + 1), "capture count");
        check(16'(capture_irq_a_o), 16'h0000, "request width");
        cfg_i.cap_a_en = 1'b0;
        // Let the filtered level fall so that the next pulse is a fresh edge.
        step(40);
        wr_cc(1'b0, 16'h1234);
        pins.hold_capture(1, 16);
        step(40);
        check(capture_compare_a_o, 16'h1234, "compare register kept");
        check(16'(irq_a_n), 16'(na + 1), "compare register request");
    endtask : t_capture

    task automatic t_capture_b;
        int nb;
        logic [15:0] v;
        run(2'h1, 2'h3, 4'h2);
        nb = irq_b_n;
        pins.hold_capture(0, 16);
        step(20);
        check(16'(irq_b_n), 16'(nb + 1), "pin a capture");
        check(16'(capture_compare_b_o != 16'h0000), 16'h0001, "pin a loads b");
        run(2'h1, 2'h3, 4'ha);
        v = capture_compare_b_o;
        pins.hold_capture(0, 16);
        step(20);
        check(up_counter_o, 16'h0001, "count on pin edge");
        check(capture_compare_b_o, v, "b with pin clock");
        check(16'(irq_b_n), 16'(nb + 1), "b request with pin clock");
    endtask : t_capture_b

    task automatic t_read;
        logic [15:0] exp;
        logic [15:0] v;
        run(2'h1, 2'h3, 4'h6);
        step(20);
        v = capture_compare_b_o;
        rd_sel_i = tmr16_pkg::RD_COUNTER;
        rd_i = 1'b1;
        exp = up_counter_o;
        step(1);
        rd_sel_i = tmr16_pkg::RD_CC_B;
        check(read_data_o, exp, "counter read");
        check(capture_compare_b_o, v, "b after counter read");
        step(1);
        check(read_data_o, v, "register b read");
        rd_sel_i = tmr16_pkg::RD_CC_A;
        v = capture_compare_a_o;
        step(1);
        fork
            pins.hold_capture(1, 16);
            repeat (90)
            begin
                step(1);
                check(read_data_o, capture_compare_a_o, "read during capture");
            end
        join
        rd_i = 1'b0;
        check(16'(capture_compare_a_o != v), 16'h0001, "capture beats read");
    endtask : t_read

    task automatic t_oneshot;
        int n;
        wr_cc(1'b1, 16'h0002);
        wr_cc(1'b0, 16'h0004);
        for (int m = 1; m < 4; m++)
        begin
            run(2'(m), 2'h0, 4'h1);
            step(4);
            n = os_n;
            oneshot_sw_trig_i = 1'b1;
            step(1);
            oneshot_sw_trig_i = 1'b0;
            step(60);
            check(16'(os_n - n), 16'(m != 3), "one-shot per mode");
            check(16'(oneshot_o), 16'h0000, "one-shot ended");
        end
        run(2'h1, 2'h0, 4'h1);
        step(40);
        n = os_n;
        pins.hold_capture(0, 2);
        for (int i = 0; i < 40 && oneshot_o !== 1'b1; i++) step(1);
        step(1);
        check(16'(os_n - n), 16'h0001, "pin a trigger pulse");
        check(16'(up_counter_o < 16'h0008), 16'h0001, "pin a clears counter");
    endtask : t_oneshot

    task automatic t_overflow;
        run(2'h0, 2'h0, 4'h0);
        wr_cc(1'b0, 16'hffff);
        run(2'h1, 2'h0, 4'h0);
        for (int i = 0; i < 140000 && up_counter_o !== 16'hffff; i++) step(1);
        check(16'(overflow_flag_o), 16'h0000, "flag before wrap");
        for (int i = 0; i < 4 && up_counter_o !== 16'h0000; i++) step(1);
        check(16'(overflow_flag_o), 16'h0001, "flag after wrap");
        ovf_clear_i = 1'b1;
        step(1);
        ovf_clear_i = 1'b0;
        check(16'(overflow_flag_o), 16'h0001, "clear before 0001");
        for (int i = 0; i < 4 && up_counter_o !== 16'h0001; i++) step(1);
        ovf_clear_i = 1'b1;
        step(1);
        ovf_clear_i = 1'b0;
        step(1);
        check(16'(overflow_flag_o), 16'h0000, "clear after 0001");
    endtask : t_overflow

    // ------------------------------------------------------------
    // Main sequence and watchdog
    // ------------------------------------------------------------
    initial
    begin
        reset_i = 1'b1;
        cfg_i = 8'h00;
        {ovf_clear_i, oneshot_sw_trig_i, cc_a_wr_i, cc_b_wr_i, rd_i} = 5'h00;
        wr_data_i = 16'h0000;
        rd_sel_i = tmr16_pkg::RD_COUNTER;
        repeat (12) @(posedge clock_i);
        #1;
        reset_i = 1'b0;
        step(1);
        t_reset();
        t_stopped();
        t_count();
        t_capture();
        t_capture_b();
        t_read();
        t_oneshot();
        t_overflow();
        finish_test();
    end

    initial
    begin
        repeat (200000) @(posedge clock_i);
        num_errors++;
        $display("mismatch at %0t: watchdog expired", $time);
        finish_test();
    end
endmodule : tmr16_timer_tb
